// ### hdl/imr_exec.sv
// Executor for indirect moves, config load, software reset and returns
// What this block does
// RQ1: Mode 00/01/10/11 is pre-inc/pre-dec/post-inc/post-dec.
// RQ2: Indirect move carries one byte between accumulator and window.
// RQ3: Window is redirected to pointer-addressed data location.
// RQ4: Sixteen-bit pointer wraps at both ends.
// RQ5: Pointer stepping leaves every status flag alone.
// RQ6: Config load copies accumulator, one cycle, no flags.
// RQ7: Software reset resets device, clears reset-instruction flag.
// RQ8: Interrupt return pops stack into program counter.
// RQ9: Interrupt return sets enable bit seven.
// RQ10: Interrupt return takes two cycles.
// RQ11: Subroutine return pops stack, flags and enable untouched.
// RQ12: Subroutine return takes two cycles.
// RQ13: Offset form addresses pointer plus offset, pointer kept.
// RQ14: Idle instruction only advances program counter.
`timescale 1ns/10ps
module imr_exec (
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [imr_pkg::OP_W-1:0] instr_op,
    input wire logic instr_ptr_sel,
    input wire logic [1:0] pointer_update_mode,
    input wire logic [imr_pkg::OFS_W-1:0] instr_offset,
    output logic busy,
    // Accumulator and zero flag
    input wire logic [imr_pkg::DATA_W-1:0] acc_in,
    output logic acc_we,
    output logic [imr_pkg::DATA_W-1:0] acc_wdata,
    output logic status_z_we,
    output logic status_z,
    // Data memory
    output logic [imr_pkg::PTR_W-1:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [imr_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [imr_pkg::DATA_W-1:0] mem_rdata,
    // Indirect pointers
    input wire logic ptr_wr,
    input wire logic ptr_wr_sel,
    input wire logic [imr_pkg::PTR_W-1:0] ptr_wr_data,
    output logic [imr_pkg::NUM_PTR-1:0][imr_pkg::PTR_W-1:0] indirect_pointer,
    // Program counter and stack
    input wire logic [imr_pkg::PC_W-1:0] stack_top,
    output logic stack_pop,
    output logic pc_load,
    output logic [imr_pkg::PC_W-1:0] pc_load_val,
    output logic pc_inc,
    // Timer configuration and interrupt control
    output logic [imr_pkg::DATA_W-1:0] timer_cfg,
    input wire logic irq_ctl_wr,
    input wire logic [imr_pkg::DATA_W-1:0] irq_ctl_wdata,
    input wire logic irq_entry,
    output logic [imr_pkg::DATA_W-1:0] irq_control_register,
    // Device reset
    input wire logic ri_set,
    output logic dev_reset_req,
    output logic reset_instr_flag_n
);
    import imr_pkg::*;

    imr_state_t state_r;
    imr_state_t state_nxt;
    logic [PTR_W-1:0] ptr_r [NUM_PTR];
    logic busy_r;
    logic acc_we_r;
    logic [DATA_W-1:0] acc_wdata_r;
    logic status_z_we_r;
    logic status_z_r;
    logic [PTR_W-1:0] mem_addr_r;
    logic mem_re_r;
    logic mem_we_r;
    logic [DATA_W-1:0] mem_wdata_r;
    logic stack_pop_r;
    logic pc_load_r;
    logic [PC_W-1:0] pc_load_val_r;
    logic pc_inc_r;
    logic ret_gie_r;
    logic [DATA_W-1:0] timer_cfg_r;
    logic [DATA_W-1:0] irq_ctl_r;
    logic [DATA_W-1:0] irq_ctl_nxt;
    logic dev_reset_req_r;

    imr_ptr_if ptr_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Requests are taken only in the idle state
    wire accept = instr_valid && (state_r == ST_IDLE);
    wire op_load = (instr_op == OP_IND_LOAD) || (instr_op == OP_IND_LOAD_REL);
    wire op_store = (instr_op == OP_IND_STORE) || (instr_op == OP_IND_STORE_REL);
    wire op_rel = (instr_op == OP_IND_LOAD_REL) || (instr_op == OP_IND_STORE_REL);
    wire op_move = op_load || op_store;
    wire op_idle = (instr_op == OP_IDLE);
    wire op_cfg = (instr_op == OP_CFG_LOAD);
    wire op_rst = (instr_op == OP_SW_RESET);
    wire op_iret = (instr_op == OP_IRQ_RETURN);
    wire op_ret = op_iret || (instr_op == OP_SUB_RETURN);
    // Unknown codes are taken as idle so the program never stalls
    wire op_single = !(op_load || op_ret || op_rst);
    wire take_load = accept && op_load;
    wire take_store = accept && op_store;
    wire take_move = accept && op_move;
    wire take_ret = accept && op_ret;
    wire in_rd_data = (state_r == ST_RD_DATA);
    wire in_ret = (state_r == ST_RET);
    wire gie_set = in_ret && ret_gie_r;

    // Pointer arithmetic sees the selected pointer
    assign ptr_bus.ptr = ptr_r[instr_ptr_sel];
    assign ptr_bus.mode = pointer_update_mode;
    assign ptr_bus.rel = op_rel;
    assign ptr_bus.offset = instr_offset;

    imr_ptr_calc u_calc (
        .pb(ptr_bus)
    );

    imr_ri_flag u_ri (
        .clk(clk),
        .por_rst(por_rst),
        .ri_clear(accept && op_rst),
        .ri_set(ri_set),
        .ri_flag_n(reset_instr_flag_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Loads wait for memory; returns spend a second cycle
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (take_load)
                    state_nxt = ST_RD_ADDR;
                else if (take_ret)
                    state_nxt = ST_RET; // [RQ10] [RQ12]
                else if (accept && op_rst)
                    state_nxt = ST_HALT;
            end
            ST_RD_ADDR: state_nxt = ST_RD_DATA;
            ST_RD_DATA: state_nxt = ST_IDLE;
            ST_RET: state_nxt = ST_IDLE;
            ST_HALT: state_nxt = ST_HALT; // Left only by the reset it requested
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            busy_r <= 1'b0;
        else
            busy_r <= (state_nxt != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indirect pointers

    // Instruction stepping wins over a plain pointer write in the same cycle
    for (genvar g = 0; g < NUM_PTR; g++)
    begin : g_ptr
        wire sel_me = (instr_ptr_sel == 1'(g));
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                ptr_r[g] <= PTR_RST;
            else if (take_move && sel_me)
                ptr_r[g] <= ptr_bus.ptr_next; // [RQ2] [RQ4] [RQ13]
            else if (ptr_wr && (ptr_wr_sel == 1'(g)))
                ptr_r[g] <= ptr_wr_data;
        end
        assign indirect_pointer[g] = ptr_r[g];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory side

    // The window has no storage; every move goes out on the memory port
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_addr_r <= PTR_RST;
            mem_re_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_wdata_r <= DATA_ZERO;
        end
        else
        begin
            mem_addr_r <= take_move ? ptr_bus.eff_addr : mem_addr_r; // [RQ3]
            mem_re_r <= take_load; // [RQ3]
            mem_we_r <= take_store; // [RQ2]
            mem_wdata_r <= take_store ? acc_in : mem_wdata_r; // [RQ2]
        end
    end

    // Only the loaded byte touches the zero flag, never the stepping
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            acc_we_r <= 1'b0;
            acc_wdata_r <= DATA_ZERO;
            status_z_we_r <= 1'b0;
            status_z_r <= 1'b0;
        end
        else
        begin
            acc_we_r <= in_rd_data; // [RQ2]
            acc_wdata_r <= in_rd_data ? mem_rdata : acc_wdata_r;
            status_z_we_r <= in_rd_data; // [RQ5]
            status_z_r <= in_rd_data ? (mem_rdata == DATA_ZERO) : status_z_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter, stack and returns

    // Stack top is caught as it is popped, loaded one cycle later
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stack_pop_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_load_val_r <= '0;
            pc_inc_r <= 1'b0;
            ret_gie_r <= 1'b0;
        end
        else
        begin
            stack_pop_r <= take_ret; // [RQ8] [RQ11]
            pc_load_r <= in_ret; // [RQ10] [RQ12]
            pc_load_val_r <= take_ret ? stack_top : pc_load_val_r; // [RQ8] [RQ11]
            pc_inc_r <= (accept && op_single) || in_rd_data; // [RQ14]
            ret_gie_r <= take_ret ? op_iret : ret_gie_r;
        end
    end

    // Enable set by the return beats a clear from interrupt entry
    assign irq_ctl_nxt = ((irq_ctl_wr ? irq_ctl_wdata : irq_ctl_r)
        & ~(irq_entry ? GIE_MASK : DATA_ZERO)) | (gie_set ? GIE_MASK : DATA_ZERO); // [RQ9]

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_ctl_r <= IRQ_CTL_RST;
            timer_cfg_r <= TIMER_CFG_RST;
            dev_reset_req_r <= 1'b0;
        end
        else
        begin
            irq_ctl_r <= irq_ctl_nxt;
            timer_cfg_r <= (accept && op_cfg) ? acc_in : timer_cfg_r; // [RQ6]
            dev_reset_req_r <= dev_reset_req_r || (accept && op_rst); // [RQ7]
        end
    end

    // Outputs
    assign busy = busy_r;
    assign acc_we = acc_we_r;
    assign acc_wdata = acc_wdata_r;
    assign status_z_we = status_z_we_r;
    assign status_z = status_z_r;
    assign mem_addr = mem_addr_r;
    assign mem_re = mem_re_r;
    assign mem_we = mem_we_r;
    assign mem_wdata = mem_wdata_r;
    assign stack_pop = stack_pop_r;
    assign pc_load = pc_load_r;
    assign pc_load_val = pc_load_val_r;
    assign pc_inc = pc_inc_r;
    assign timer_cfg = timer_cfg_r;
    assign irq_control_register = irq_ctl_r;
    assign dev_reset_req = dev_reset_req_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wire plain_move = take_move && !op_rel;
    wire [PTR_W-1:0] sel_ptr = ptr_bus.ptr;

    sequence s_ret_pop;
        stack_pop_r && !pc_load_r;
    endsequence

    sequence s_ret_load;
        pc_load_r && !stack_pop_r && (pc_load_val_r == $past(stack_top, 2));
    endsequence

    property p_pre_inc;
        plain_move && (pointer_update_mode == MODE_PRE_INC) |=>
            (mem_addr_r == $past(sel_ptr) + PTR_ONE) && (ptr_r[$past(instr_ptr_sel)] == mem_addr_r);
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address wrong"); // [RQ1]

    property p_post_dec;
        plain_move && (pointer_update_mode == MODE_POST_DEC) |=>
            (mem_addr_r == $past(sel_ptr)) && (ptr_r[$past(instr_ptr_sel)] == mem_addr_r - PTR_ONE);
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong"); // [RQ1]

    property p_store;
        take_store |=> mem_we_r && !mem_re_r && (mem_wdata_r == $past(acc_in))
            ##1 (mem_we_r == $past(take_store));
    endproperty
    a_store: assert property (p_store) else $error("store byte not written once"); // [RQ2]

    property p_load;
        take_load |=> mem_re_r ##1 !acc_we_r ##1 acc_we_r && (acc_wdata_r == $past(mem_rdata));
    endproperty
    a_load: assert property (p_load) else $error("load byte not returned"); // [RQ3]

    property p_wrap;
        plain_move && (pointer_update_mode == MODE_PRE_INC) && (sel_ptr == PTR_TOP) |=>
            (mem_addr_r == PTR_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap to zero"); // [RQ4]

    property p_no_flags;
        take_store |=> !status_z_we_r [*2];
    endproperty
    a_no_flags: assert property (p_no_flags) else $error("store touched zero flag"); // [RQ5]

    property p_cfg;
        accept && op_cfg |=> (timer_cfg_r == $past(acc_in)) && !acc_we_r && !status_z_we_r && !busy_r;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config load wrong"); // [RQ6]

    property p_swrst;
        accept && op_rst |=> dev_reset_req_r && !reset_instr_flag_n;
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset not raised"); // [RQ7]

    property p_iret;
        take_ret && op_iret |=> s_ret_pop ##1 (s_ret_load and irq_ctl_r[GIE_BIT]);
    endproperty
    a_iret: assert property (p_iret) else $error("interrupt return wrong"); // [RQ10]

    property p_sret;
        take_ret && !op_iret |=> s_ret_pop ##1 (s_ret_load and !status_z_we_r);
    endproperty
    a_sret: assert property (p_sret) else $error("subroutine return wrong"); // [RQ12]

    property p_rel;
        take_move && op_rel |=> (ptr_r[$past(instr_ptr_sel)] == $past(sel_ptr))
            && (mem_addr_r == $past(sel_ptr + PTR_W'($signed(instr_offset))));
    endproperty
    a_rel: assert property (p_rel) else $error("offset form moved pointer"); // [RQ13]

    property p_idle;
        accept && op_idle |=> pc_inc_r && !mem_we_r && !mem_re_r && !acc_we_r && !stack_pop_r;
    endproperty
    a_idle: assert property (p_idle) else $error("idle did more than advance"); // [RQ14]
endmodule // imr_exec

// ### hdl/imr_pkg.sv
// Shared constants and types for the indirect-move and return executor
package imr_pkg;
    // Widths
    localparam int PTR_W = 16;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int OP_W = 4;
    localparam int OFS_W = 6;
    localparam int NUM_PTR = 2;
    // Instruction codes on the issue port
    localparam logic [OP_W-1:0] OP_IDLE = 4'h0;
    localparam logic [OP_W-1:0] OP_IND_LOAD = 4'h1;
    localparam logic [OP_W-1:0] OP_IND_STORE = 4'h2;
    localparam logic [OP_W-1:0] OP_IND_LOAD_REL = 4'h3;
    localparam logic [OP_W-1:0] OP_IND_STORE_REL = 4'h4;
    localparam logic [OP_W-1:0] OP_CFG_LOAD = 4'h5;
    localparam logic [OP_W-1:0] OP_SW_RESET = 4'h6;
    localparam logic [OP_W-1:0] OP_IRQ_RETURN = 4'h7;
    localparam logic [OP_W-1:0] OP_SUB_RETURN = 4'h8;
    // Pointer update mode encodings
    localparam logic [1:0] MODE_PRE_INC = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    // Reset values and field positions
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
    localparam logic [PTR_W-1:0] PTR_TOP = 16'hFFFF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_CFG_RST = 8'hFF;
    localparam logic [DATA_W-1:0] IRQ_CTL_RST = 8'h00;
    localparam int GIE_BIT = 7;
    localparam logic [DATA_W-1:0] GIE_MASK = 8'h80;
    localparam logic RI_RST = 1'b1;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RET_CYCLES = 2;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RD_ADDR = 5'h02,
        ST_RD_DATA = 5'h04,
        ST_RET = 5'h08,
        ST_HALT = 5'h10
    } imr_state_t;
endpackage

// ### hdl/imr_ptr_if.sv
// Carrier between the executor and its pointer arithmetic
`timescale 1ns/10ps
interface imr_ptr_if;
    import imr_pkg::*;
    logic [PTR_W-1:0] ptr;
    logic [1:0] mode;
    logic rel;
    logic [OFS_W-1:0] offset;
    logic [PTR_W-1:0] eff_addr;
    logic [PTR_W-1:0] ptr_next;
    modport calc (input ptr, input mode, input rel, input offset, output eff_addr, output ptr_next);
    modport user (output ptr, output mode, output rel, output offset, input eff_addr, input ptr_next);
endinterface

// ### hdl/imr_ptr_calc.sv
// Effective address and next pointer value for an indirect move
`timescale 1ns/10ps
module imr_ptr_calc (
    // Pointer carrier
    imr_ptr_if.calc pb
);
    import imr_pkg::*;

    // Sixteen-bit arithmetic wraps at both ends by itself
    wire [PTR_W-1:0] inc_val = pb.ptr + PTR_ONE; // [RQ4]
    wire [PTR_W-1:0] dec_val = pb.ptr - PTR_ONE; // [RQ4]
    wire [PTR_W-1:0] ofs_ext = {{(PTR_W-OFS_W){pb.offset[OFS_W-1]}}, pb.offset};
    wire [PTR_W-1:0] rel_addr = pb.ptr + ofs_ext; // [RQ13]
    wire is_inc = (pb.mode == MODE_PRE_INC) || (pb.mode == MODE_POST_INC); // [RQ1]
    wire is_pre = (pb.mode == MODE_PRE_INC) || (pb.mode == MODE_PRE_DEC); // [RQ1]
    wire [PTR_W-1:0] stepped = is_inc ? inc_val : dec_val;

    // Pre modes address the stepped value, post modes the old one
    assign pb.eff_addr = pb.rel ? rel_addr : (is_pre ? stepped : pb.ptr); // [RQ2]
    // Offset form keeps the pointer as it was
    assign pb.ptr_next = pb.rel ? pb.ptr : stepped; // [RQ13]
endmodule // imr_ptr_calc

// ### hdl/imr_ri_flag.sv
// Reset-instruction flag, held across software-requested resets
`timescale 1ns/10ps
module imr_ri_flag (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic por_rst,
    // Events
    input wire logic ri_clear,
    input wire logic ri_set,
    // Flag, low after a software reset
    output logic ri_flag_n
);
    import imr_pkg::*;

    // Only power-on resets it, else the cause would be lost; clear beats set
    always_ff @(posedge clk or posedge por_rst)
    begin
        if (por_rst)
            ri_flag_n <= RI_RST;
        else if (ri_clear)
            ri_flag_n <= 1'b0; // [RQ7]
        else if (ri_set)
            ri_flag_n <= 1'b1;
    end
endmodule // imr_ri_flag

// ### dv/tb.sv
// Self-checking bench for the indirect-move and return executor
`timescale 1ns/10ps
module tb;
    import imr_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk, sys_rst, por_rst, instr_valid, instr_ptr_sel, busy;
    logic [OP_W-1:0] instr_op;
    logic [1:0] pointer_update_mode;
    logic [OFS_W-1:0] instr_offset;
    logic [DATA_W-1:0] acc_in, acc_wdata, mem_wdata, mem_rdata, timer_cfg;
    logic [DATA_W-1:0] irq_ctl_wdata, irq_control_register;
    logic acc_we, status_z_we, status_z, mem_re, mem_we, ptr_wr, ptr_wr_sel;
    logic [PTR_W-1:0] mem_addr, ptr_wr_data;
    logic [NUM_PTR-1:0][PTR_W-1:0] indirect_pointer;
    logic [PC_W-1:0] stack_top, pc_load_val;
    logic stack_pop, pc_load, pc_inc, irq_ctl_wr, irq_entry, ri_set;
    logic dev_reset_req, reset_instr_flag_n;
    int failures, samples_checked;
    logic [PTR_W-1:0] p_exp [NUM_PTR];
    logic [PTR_W-1:0] np, ea;
    logic [3:0] op;
    logic [DATA_W-1:0] rd;
    logic sel;

    imr_exec i_imr_exec (.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_ptr_sel(instr_ptr_sel),
        .pointer_update_mode(pointer_update_mode), .instr_offset(instr_offset), .busy(busy),
        .acc_in(acc_in), .acc_we(acc_we), .acc_wdata(acc_wdata), .status_z_we(status_z_we),
        .status_z(status_z), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ptr_wr(ptr_wr), .ptr_wr_sel(ptr_wr_sel),
        .ptr_wr_data(ptr_wr_data), .indirect_pointer(indirect_pointer),
        .stack_top(stack_top), .stack_pop(stack_pop), .pc_load(pc_load),
        .pc_load_val(pc_load_val), .pc_inc(pc_inc), .timer_cfg(timer_cfg),
        .irq_ctl_wr(irq_ctl_wr), .irq_ctl_wdata(irq_ctl_wdata), .irq_entry(irq_entry),
        .irq_control_register(irq_control_register), .ri_set(ri_set),
        .dev_reset_req(dev_reset_req), .reset_instr_flag_n(reset_instr_flag_n));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    // Single compare for every kind of result, zero-extended to one width
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One instruction request; returns just after the taking edge settles
    task automatic issue(input logic [3:0] o, input logic s, input logic [1:0] md,
                         input logic [5:0] ofs);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= o;
        instr_ptr_sel <= s;
        pointer_update_mode <= md;
        instr_offset <= ofs;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // Side-band one-cycle strobes share this shape
    task automatic side_wr(input int kind, input logic s, input logic [15:0] d);
        @(posedge clk);
        ptr_wr <= (kind == 0);
        irq_ctl_wr <= (kind == 1);
        irq_entry <= (kind == 2);
        ri_set <= (kind == 3);
        ptr_wr_sel <= s;
        ptr_wr_data <= d;
        irq_ctl_wdata <= d[7:0];
        @(posedge clk);
        {ptr_wr, irq_ctl_wr, irq_entry, ri_set} <= 4'h0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the fewer than a hundred cycles the tests need
    initial
    begin
        #(CLK_PERIOD_NS * 5000);
        failures++;
        test_done();
    end

    // Main sequence
    initial
    begin
        failures = 0;
        samples_checked = 0;
        {instr_valid, instr_ptr_sel, ptr_wr, ptr_wr_sel, irq_ctl_wr, irq_entry, ri_set} = 7'h00;
        instr_op = OP_IDLE;
        pointer_update_mode = 2'h0;
        instr_offset = 6'h00;
        acc_in = 8'h00;
        mem_rdata = 8'h00;
        ptr_wr_data = 16'h0000;
        stack_top = 15'h0000;
        irq_ctl_wdata = 8'h00;
        sys_rst = 1'b1;
        por_rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk(timer_cfg, 32'hFF);
        chk(irq_control_register, 32'h00);
        chk(indirect_pointer, 32'h0000_0000);
        chk(reset_instr_flag_n, 32'h1);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        // Moves in every mode on both pointers, chained through both wrap points
        side_wr(0, 1'b1, 16'hFFFF);
        side_wr(0, 1'b0, 16'h1234);
        p_exp[0] = 16'h1234;
        p_exp[1] = 16'hFFFF;
        for (int i = 0; i < 8; i++)
        begin
            op = (i < 4) ? OP_IND_STORE : OP_IND_LOAD;
            sel = (i < 4);
            rd = (i == 5) ? 8'h00 : 8'hA0 + 8'(i);
            np = p_exp[sel] + (i[0] ? 16'hFFFF : 16'h0001);
            ea = i[1] ? p_exp[sel] : np;
            acc_in <= 8'h50 + 8'(i);
            mem_rdata <= rd;
            issue(op, sel, 2'(i), 6'h00);
            chk(mem_addr, ea);
            chk(indirect_pointer[sel], np);
            chk(indirect_pointer[!sel], p_exp[!sel]);
            chk({mem_we, mem_re, status_z_we}, (i < 4) ? 32'h4 : 32'h2);
            if (i < 4)
                chk({mem_wdata, pc_inc}, {8'h50 + 8'(i), 1'b1});
            else
            begin
                repeat (2) @(posedge clk);
                #1;
                chk({acc_we, acc_wdata, status_z_we, status_z}, {1'b1, rd, 1'b1, rd == 8'h00});
            end
            p_exp[sel] = np;
        end
        // Offset form at both ends of the offset range, pointer kept
        for (int i = 0; i < 2; i++)
        begin
            acc_in <= 8'h3C;
            issue(i ? OP_IND_LOAD_REL : OP_IND_STORE_REL, 1'b0, 2'h0, i ? 6'h1F : 6'h20);
            chk(mem_addr, 16'(p_exp[0] + (i ? 16'h001F : 16'hFFE0)));
            chk(indirect_pointer[0], p_exp[0]);
            chk({mem_we, mem_re}, i ? 32'h1 : 32'h2);
            if (i)
                repeat (2) @(posedge clk);
        end
        // Config load then idle, with instr_valid low for one cycle between them
        acc_in <= 8'h4F;
        issue(OP_CFG_LOAD, 1'b0, 2'h0, 6'h00);
        chk({timer_cfg, acc_we, status_z_we, pc_inc}, {8'h4F, 3'h1});
        acc_in <= 8'h77;
        issue(OP_IDLE, 1'b1, 2'h0, 6'h00);
        chk({pc_inc, acc_we, mem_we, mem_re, status_z_we, pc_load}, 32'h20);
        chk(timer_cfg, 32'h4F);
        chk(indirect_pointer, {p_exp[1], p_exp[0]});
        // Undefined codes behave as idle
        issue(4'hA, 1'b0, 2'h0, 6'h00);
        chk({pc_inc, mem_we, mem_re, busy, timer_cfg}, {4'h8, 8'h4F});
        // Interrupt control writes and entry clear
        side_wr(1, 1'b0, 16'h0095);
        side_wr(2, 1'b0, 16'h0000);
        chk(irq_control_register, 32'h15);
        // Interrupt return, then subroutine return with enable low again
        for (int i = 0; i < 2; i++)
        begin
            stack_top <= i ? 15'h1357 : 15'h2ABC;
            issue(i ? OP_SUB_RETURN : OP_IRQ_RETURN, 1'b0, 2'h0, 6'h00);
            chk({stack_pop, pc_load, busy, pc_inc}, 32'hA);
            @(posedge clk);
            #1;
            chk({stack_pop, pc_load, busy, pc_inc}, 32'h4);
            chk(pc_load_val, i ? 32'h1357 : 32'h2ABC);
            chk(irq_control_register, i ? 32'h15 : 32'h95);
            chk(status_z_we, 32'h0);
            if (!i)
                side_wr(1, 1'b0, 16'h0015);
        end
        // Software reset: request raised, flag cleared, further requests ignored
        issue(OP_SW_RESET, 1'b0, 2'h0, 6'h00);
        chk({dev_reset_req, reset_instr_flag_n, pc_inc}, 32'h4);
        issue(OP_IND_STORE, 1'b0, 2'h0, 6'h00);
        chk({mem_we, pc_inc, dev_reset_req}, 32'h1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({dev_reset_req, reset_instr_flag_n, timer_cfg}, {2'b00, 8'hFF});
        chk(indirect_pointer, 32'h0000_0000);
        side_wr(3, 1'b0, 16'h0000);
        @(posedge clk);
        #1;
        chk(reset_instr_flag_n, 32'h1);
        test_done();
    end
endmodule // tb
